// file: logic/pmsbc_top.sv
/*
 * Operating-mode sequencer with boost control registers and PWM core.
 * Assumes the register port is synchronous to clk_sys, the internal
 * oscillator drives clk_sys, and power-on reset comes from the analog side.
 */
`timescale 1ns/100ps
`include "pmsbc_params.svh"
module pmsbc_top #(
    parameter int STARTUP_CYC = `PMSBC_STARTUP_CYC,
    parameter int SOFT_CYC = `PMSBC_SOFT_CYC
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic ext_reset_n,
    input wire logic por_active,
    input wire logic thermal_shutdown,
    input wire logic current_trip,
    input wire logic reg_wr,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output pmsbc_pkg::pmsbc_mode_t mode,
    output logic circuits_on,
    output logic led_enable,
    output pmsbc_pkg::pmsbc_bst_t boost_mode,
    output logic [7:0] boost_target,
    output logic boost_switch,
    output logic active_load_on
);
    import pmsbc_pkg::*;

    pmsbc_bst_if bst ();

    logic in_reset;
    logic [7:0] ctrl;
    logic [7:0] next_ctrl;
    logic [7:0] vsel;
    logic [7:0] next_vsel;
    logic [7:0] rdata;
    logic [7:0] next_rdata;
    pmsbc_mode_t next_mode;
    logic [24:0] timer;
    logic [24:0] next_timer;
    logic boost_q;
    logic [7:0] target_clamped;
    logic [7:0] target_q;
    logic [7:0] next_target_q;
    logic active_req;
    logic boost_req;
    logic boost_rise;

    // Either reset source forces the reset state with no other condition
    assign in_reset = !ext_reset_n || por_active;

    assign active_req = ctrl[`PMSBC_BIT_ACTIVE];
    assign boost_req = ctrl[`PMSBC_BIT_BOOST];
    // Boost enable rising in normal mode restarts the soft start
    assign boost_rise = boost_req && !boost_q;

    // Register port; writes accepted whenever neither reset input is asserted, whatever the mode
    always_comb begin
        next_ctrl = ctrl;
        next_vsel = vsel;
        next_rdata = 8'h0_0;
        if (in_reset) begin
            next_ctrl = `PMSBC_CTRL_RST;
            next_vsel = `PMSBC_VSEL_RST;
        end else if (reg_wr) begin
            // Whole-byte writes, so any mix of bits changes at once
            unique case (reg_addr)
                `PMSBC_OFS_CTRL: begin
                    next_ctrl = {5'h0_0, reg_wdata[2:0]};
                end
                `PMSBC_OFS_VSEL: begin
                    next_vsel = reg_wdata;
                end
                default: begin
                end
            endcase
        end
        // Unmapped addresses read as zero
        unique case (reg_addr)
            `PMSBC_OFS_CTRL: next_rdata = ctrl;
            `PMSBC_OFS_VSEL: next_rdata = vsel;
            `PMSBC_OFS_STAT: next_rdata = {3'h0, thermal_shutdown, 1'b0, 3'(mode)};
            default: next_rdata = 8'h0_0;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            ctrl <= `PMSBC_CTRL_RST;
            vsel <= `PMSBC_VSEL_RST;
            rdata <= 8'h0_0;
        end else begin
            ctrl <= next_ctrl;
            vsel <= next_vsel;
            rdata <= next_rdata;
        end
    end

    assign reg_rdata = rdata;

    // Mode sequencer; delays are cycle counts on the oscillator clock
    always_comb begin
        next_mode = mode;
        next_timer = timer;
        if (in_reset) begin
            next_mode = PMSBC_RESET;
            next_timer = 25'h0;
        end else if (!active_req) begin
            next_mode = PMSBC_STANDBY;
            next_timer = 25'h0;
        end else begin
            unique case (mode)
                PMSBC_RESET: begin
                    next_mode = PMSBC_STANDBY;
                    next_timer = 25'h0;
                end
                PMSBC_STANDBY: begin
                    next_mode = PMSBC_STARTUP;
                    next_timer = 25'h0;
                end
                PMSBC_STARTUP: begin
                    if (thermal_shutdown) begin
                        next_timer = 25'h0;
                    end else if (timer >= 25'(STARTUP_CYC - 1)) begin
                        next_timer = 25'h0;
                        next_mode = boost_req ? PMSBC_BOOST_SOFT : PMSBC_NORMAL;
                    end else begin
                        next_timer = timer + 25'h1;
                    end
                end
                PMSBC_BOOST_SOFT: begin
                    if (thermal_shutdown) begin
                        next_mode = PMSBC_STARTUP;
                        next_timer = 25'h0;
                    end else if (!boost_req) begin
                        next_mode = PMSBC_NORMAL;
                        next_timer = 25'h0;
                    end else if (timer >= 25'(SOFT_CYC - 1)) begin
                        next_mode = PMSBC_NORMAL;
                        next_timer = 25'h0;
                    end else begin
                        next_timer = timer + 25'h1;
                    end
                end
                PMSBC_NORMAL: begin
                    next_timer = 25'h0;
                    if (thermal_shutdown) begin
                        next_mode = PMSBC_STARTUP;
                    end else if (boost_rise) begin
                        next_mode = PMSBC_BOOST_SOFT;
                    end
                end
                // Unused codes, or an unknown state before the first reset, fall back to reset
                default: begin
                    next_mode = PMSBC_RESET;
                    next_timer = 25'h0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            mode <= PMSBC_RESET;
            timer <= 25'h0;
            boost_q <= 1'b0;
        end else begin
            mode <= next_mode;
            timer <= next_timer;
            boost_q <= boost_req;
        end
    end

    // Clamped target registered so the feedback divider sees a clean code
    pmsbc_clamp u_clamp (
        .code_in(vsel),
        .code_out(target_clamped)
    );

    always_comb begin
        next_target_q = target_clamped;
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            target_q <= `PMSBC_VSEL_MIN;
        end else begin
            target_q <= next_target_q;
        end
    end

    // Converter mode follows the sequencer; boost off unless enabled
    always_comb begin
        bst.mode = PMSBC_BST_OFF;
        if (mode == PMSBC_BOOST_SOFT) begin
            bst.mode = PMSBC_BST_LOWCUR;
        end else if (mode == PMSBC_NORMAL && boost_req && boost_q) begin
            // A fresh enable waits one cycle for soft start, so full PWM never runs unsoftened
            bst.mode = PMSBC_BST_PWM;
        end
    end

    assign bst.vsel = target_q;
    assign bst.load_en = ctrl[`PMSBC_BIT_LOAD];

    pmsbc_pwm u_pwm (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .current_trip(current_trip),
        .bst(bst)
    );

    // Outputs; LEDs held off through soft start, since supply is still ramping
    assign circuits_on = (mode == PMSBC_STARTUP) || (mode == PMSBC_BOOST_SOFT)
        || (mode == PMSBC_NORMAL);
    assign led_enable = (mode == PMSBC_NORMAL) && !thermal_shutdown;
    assign boost_mode = bst.mode;
    assign boost_target = target_q;
    assign boost_switch = bst.sw_on;
    assign active_load_on = bst.load_on;
endmodule

// file: inc/pmsbc_params.svh
/*
 * Constants for the operating-mode sequencer and boost control: register
 * offsets, field positions, reset values and timing counts.
 * Assumes a 100 MHz clk_sys and an 8-bit register port with write strobe.
 */
`ifndef PMSBC_PARAMS_SVH
`define PMSBC_PARAMS_SVH

// Register offsets on the internal register port
`define PMSBC_OFS_CTRL 8'h0_0
`define PMSBC_OFS_VSEL 8'h0_D
`define PMSBC_OFS_STAT 8'h0_E

// Control register fields
`define PMSBC_BIT_ACTIVE 0
`define PMSBC_BIT_BOOST 1
`define PMSBC_BIT_LOAD 2

// Reset values
`define PMSBC_CTRL_RST 8'h0_4
`define PMSBC_VSEL_RST 8'h0_8

// Boost output code range
`define PMSBC_VSEL_MIN 8'h0_8
`define PMSBC_VSEL_MAX 8'h1_4

// Timing
`define PMSBC_CLK_HZ 100000000
`define PMSBC_STARTUP_MS 10
`define PMSBC_SOFT_MS 20
`define PMSBC_STARTUP_CYC ((`PMSBC_CLK_HZ / 1000) * `PMSBC_STARTUP_MS)
`define PMSBC_SOFT_CYC ((`PMSBC_CLK_HZ / 1000) * `PMSBC_SOFT_MS)
`define PMSBC_PERIOD_NS 1000
`define PMSBC_PERIOD_CYC (`PMSBC_PERIOD_NS / 10)
`define PMSBC_MIN_PULSE_NS 45
`define PMSBC_MIN_PULSE_CYC ((`PMSBC_MIN_PULSE_NS + 9) / 10)
`define PMSBC_MAX_DUTY_CYC 90

`endif

// file: inc/pmsbc_pkg.sv
/*
 * Types for the operating-mode sequencer and boost control.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package pmsbc_pkg;
    // Chip operating modes
    typedef enum logic [2:0] {
        PMSBC_RESET,
        PMSBC_STANDBY,
        PMSBC_STARTUP,
        PMSBC_BOOST_SOFT,
        PMSBC_NORMAL
    } pmsbc_mode_t;

    // Converter modes
    typedef enum logic [1:0] {
        PMSBC_BST_OFF,
        PMSBC_BST_LOWCUR,
        PMSBC_BST_PWM
    } pmsbc_bst_t;
endpackage

// file: inc/pmsbc_bst_if.sv
/*
 * Carrier between the mode sequencer and the PWM core.
 * Assumes both ends share clk_sys.
 */
`timescale 1ns/100ps
interface pmsbc_bst_if;
    import pmsbc_pkg::*;
    pmsbc_bst_t mode;
    logic [7:0] vsel;
    logic load_en;
    logic sw_on;
    logic load_on;

    modport seq (output mode, output vsel, output load_en, input sw_on, input load_on);
    modport pwm (input mode, input vsel, input load_en, output sw_on, output load_on);
endinterface

// file: logic/pmsbc_clamp.sv
/*
 * Clamps the boost output code into the valid voltage range.
 * Assumes a registered code at its input.
 */
`timescale 1ns/100ps
`include "pmsbc_params.svh"
module pmsbc_clamp (
    input wire logic [7:0] code_in,
    output logic [7:0] code_out
);
    import pmsbc_pkg::*;

    // Out-of-range codes saturate rather than wrap
    always_comb begin
        if (code_in < `PMSBC_VSEL_MIN) begin
            code_out = `PMSBC_VSEL_MIN;
        end else if (code_in > `PMSBC_VSEL_MAX) begin
            code_out = `PMSBC_VSEL_MAX;
        end else begin
            code_out = code_in;
        end
    end
endmodule

// file: logic/pmsbc_pwm.sv
/*
 * Digital switch timing of the boost converter: fixed period, a minimum
 * pulse every period, a duty cap, and the active-load gate.
 * Assumes the analog loop supplies a current-trip level each cycle.
 */
`timescale 1ns/100ps
`include "pmsbc_params.svh"
module pmsbc_pwm #(
    parameter int PERIOD = `PMSBC_PERIOD_CYC,
    parameter int MIN_PULSE = `PMSBC_MIN_PULSE_CYC,
    parameter int MAX_DUTY = `PMSBC_MAX_DUTY_CYC
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic current_trip,
    pmsbc_bst_if.pwm bst
);
    import pmsbc_pkg::*;

    logic [7:0] phase;
    logic [7:0] next_phase;
    logic sw_q;
    logic next_sw_q;

    // Phase counter and switch latch; trip ends the pulse only after the minimum width
    always_comb begin
        next_phase = (phase == 8'(PERIOD - 1)) ? 8'h0_0 : phase + 8'h0_1;
        next_sw_q = sw_q;
        if (bst.mode == PMSBC_BST_OFF) begin
            next_phase = 8'h0_0;
            next_sw_q = 1'b0;
        end else if (phase == 8'(PERIOD - 1)) begin
            next_sw_q = 1'b1;
        end else if (phase >= 8'(MAX_DUTY - 1)) begin
            next_sw_q = 1'b0;
        end else if (phase >= 8'(MIN_PULSE - 1) && current_trip) begin
            next_sw_q = 1'b0;
        end else if (bst.mode == PMSBC_BST_LOWCUR && phase >= 8'(2 * MIN_PULSE - 1)) begin
            next_sw_q = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            phase <= 8'h0_0;
            sw_q <= 1'b0;
        end else begin
            phase <= next_phase;
            sw_q <= next_sw_q;
        end
    end

    // Active load only while switching; off when disabled, accepting pulse skipping
    assign bst.sw_on = sw_q;
    assign bst.load_on = bst.load_en && (bst.mode != PMSBC_BST_OFF);
endmodule

// file: verif/pmsbc_top_chk.sv
/* Assertions on the ports of the mode sequencer and boost control top.
   Assumes a bind onto pmsbc_top with its count parameters. */
`timescale 1ns/100ps
module pmsbc_top_chk #(
    parameter int STARTUP_CYC = 20,
    parameter int SOFT_CYC = 40
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic ext_reset_n,
    input wire logic por_active,
    input wire logic thermal_shutdown,
    input wire logic reg_wr,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input pmsbc_pkg::pmsbc_mode_t mode,
    input wire logic circuits_on,
    input wire logic led_enable,
    input pmsbc_pkg::pmsbc_bst_t boost_mode,
    input wire logic [7:0] boost_target,
    input wire logic boost_switch,
    input wire logic active_load_on
);
    import pmsbc_pkg::*;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    pmsbc_mode_t prev_mode;
    int md_cnt, next_md_cnt, hi_cnt, next_hi_cnt, lo_cnt, next_lo_cnt;
    wire logic quiet_rst = ext_reset_n && !por_active;

    // Run lengths of a mode, of switch-on, and of switch-off under PWM
    always_comb begin
        next_md_cnt = (mode == prev_mode) ? md_cnt + 1 : 0;
        next_hi_cnt = boost_switch ? hi_cnt + 1 : 0;
        next_lo_cnt = (!boost_switch && boost_mode == PMSBC_BST_PWM) ? lo_cnt + 1 : 0;
    end
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            prev_mode <= PMSBC_RESET;
            md_cnt <= 0;
            hi_cnt <= 0;
            lo_cnt <= 0;
        end else begin
            prev_mode <= mode;
            md_cnt <= next_md_cnt;
            hi_cnt <= next_hi_cnt;
            lo_cnt <= next_lo_cnt;
        end
    end

    rst_hold_a: assert property (!quiet_rst |=> mode == PMSBC_RESET)
        else $error("reset input did not force reset mode");
    rst_dflt_a: assert property ((!ext_reset_n) [*3] |-> boost_target == 8'h0_8 && !circuits_on)
        else $error("defaults not restored in reset");
    stby_quiet_a: assert property (mode == PMSBC_STANDBY |-> !circuits_on && !led_enable)
        else $error("functions active in standby");
    soft_quiet_a: assert property (mode == PMSBC_BOOST_SOFT
        |-> !led_enable && boost_mode == PMSBC_BST_LOWCUR)
        else $error("soft start without low current or with LEDs on");
    therm_hold_a: assert property (thermal_shutdown && quiet_rst
        && mode inside {PMSBC_STARTUP, PMSBC_BOOST_SOFT, PMSBC_NORMAL}
        |=> !led_enable && mode inside {PMSBC_STARTUP, PMSBC_STANDBY, PMSBC_RESET})
        else $error("thermal event did not hold startup");
    code_clamp_a: assert property (boost_target >= 8'h0_8 && boost_target <= 8'h1_4)
        else $error("boost target outside 8 to 20");
    startup_len_a: assert property (mode == PMSBC_BOOST_SOFT && prev_mode == PMSBC_STARTUP
        |-> md_cnt >= STARTUP_CYC - 3)
        else $error("startup delay too short");
    soft_len_a: assert property (mode == PMSBC_NORMAL && prev_mode == PMSBC_BOOST_SOFT
        && boost_mode == PMSBC_BST_PWM |-> md_cnt >= SOFT_CYC - 3 && md_cnt <= SOFT_CYC + 1)
        else $error("soft start length wrong");
    stby_ret_a: assert property (reg_wr && reg_addr == 8'h0_0 && !reg_wdata[0] && quiet_rst
        && mode != PMSBC_RESET ##1 quiet_rst |-> ##[0:1] mode == PMSBC_STANDBY)
        else $error("clearing active request did not reach standby");
    sw_off_a: assert property ((boost_mode == PMSBC_BST_OFF) [*2] |-> !boost_switch)
        else $error("switching while converter off");
    load_gate_a: assert property (active_load_on |-> boost_mode != PMSBC_BST_OFF)
        else $error("active load on with converter off");
    duty_cap_a: assert property (hi_cnt <= 90)
        else $error("switch on beyond duty limit");
    pulse_each_a: assert property (lo_cnt <= 100)
        else $error("no switch pulse within a period");
    pwm_entry_a: assert property (boost_mode == PMSBC_BST_PWM |-> $past(boost_mode) != PMSBC_BST_OFF)
        else $error("full PWM started without soft start");
endmodule

bind pmsbc_top pmsbc_top_chk #(.STARTUP_CYC(STARTUP_CYC), .SOFT_CYC(SOFT_CYC)) chk (
    .clk_sys, .rst_b, .ext_reset_n, .por_active, .thermal_shutdown, .reg_wr, .reg_addr,
    .reg_wdata, .mode, .circuits_on, .led_enable, .boost_mode, .boost_target,
    .boost_switch, .active_load_on);

// file: verif/test_power_mode_sequencer_boost_ctrl.sv
/* Self-checking bench for the mode sequencer and boost control top.
   Assumes the checker file is compiled with it and binds itself. */
`timescale 1ns/100ps
module test_power_mode_sequencer_boost_ctrl;
    import pmsbc_pkg::*;
    localparam int ST = 20;
    localparam int SF = 40;
    localparam logic [7:0] CORNER [6] = '{8'h0_0, 8'h0_7, 8'h0_8, 8'h1_4, 8'h1_5, 8'hF_F};
    logic clk_sys = 0, rst_b = 0, ext_reset_n = 1, por_active = 0;
    logic thermal_shutdown = 0, current_trip = 0, reg_wr = 0;
    logic [7:0] reg_addr = 8'h0_0, reg_wdata = 8'h0_0, rd;
    logic [7:0] reg_rdata, boost_target;
    pmsbc_mode_t mode;
    pmsbc_bst_t boost_mode;
    logic circuits_on, led_enable, boost_switch, active_load_on;
    int error_cnt = 0, n_compared = 0, seed = 68420;
    // Packed status view: led, circuits, load, then converter mode
    wire logic [7:0] outs = {led_enable, circuits_on, active_load_on, 3'h0, boost_mode};

    pmsbc_top #(.STARTUP_CYC(ST), .SOFT_CYC(SF)) dut (
        .clk_sys, .rst_b, .ext_reset_n, .por_active, .thermal_shutdown, .current_trip,
        .reg_wr, .reg_addr, .reg_wdata, .reg_rdata, .mode, .circuits_on, .led_enable,
        .boost_mode, .boost_target, .boost_switch, .active_load_on);

    initial forever #5 clk_sys = ~clk_sys;
    // Random loop trips keep the PWM core busy throughout
    always @(posedge clk_sys) current_trip <= 1'($random(seed));

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // One-cycle write strobe; the next call waits an edge before raising it again
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    // Read data is registered, so sample two edges after the address
    task automatic rd_reg(input logic [7:0] a);
        @(posedge clk_sys);
        reg_addr <= a;
        repeat (2) @(posedge clk_sys);
        #1 rd = reg_rdata;
    endtask
    task automatic wait_mode(input pmsbc_mode_t m);
        int i;
        for (i = 0; i < 200 && mode !== m; i++) @(posedge clk_sys);
        #1 check(8'(mode), 8'(m));
    endtask
    function automatic logic [7:0] clamp(input logic [7:0] v);
        return (v < 8'h0_8) ? 8'h0_8 : (v > 8'h1_4) ? 8'h1_4 : v;
    endfunction
    task automatic final_report();
        if (error_cnt == 0 && n_compared > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    // Watchdog: the sequence needs a few hundred cycles at most
    initial begin
        #200000;
        error_cnt++;
        final_report();
    end

    initial begin
        logic [7:0] v;
        int k;
        repeat (5) @(posedge clk_sys);
        rst_b <= 1'b1;
        rd_reg(8'h0_0);
        check(rd, 8'h0_4);
        rd_reg(8'h3_3);
        check(rd, 8'h0_0);
        rd_reg(8'h0_E);
        check(rd, 8'h0_1);
        check(outs, 8'h0_0);
        // Below-range code written in standby clamps to the lowest target; no boost yet
        wr(8'h0_D, 8'h0_3);
        wr(8'h0_0, 8'h0_1);
        wait_mode(PMSBC_STARTUP);
        wait_mode(PMSBC_NORMAL);
        check(outs, 8'hC_0);
        check(boost_target, 8'h0_8);
        // Boost enable from normal runs soft start
        wr(8'h0_0, 8'h0_7);
        wait_mode(PMSBC_BOOST_SOFT);
        check(outs, 8'h6_1);
        wait_mode(PMSBC_NORMAL);
        check(outs, 8'hE_2);
        // Corner codes first, then random ones
        for (k = 0; k < 14; k++) begin
            v = (k < 6) ? CORNER[k] : 8'($random(seed));
            wr(8'h0_D, v);
            repeat (3) @(posedge clk_sys);
            #1 check(boost_target, clamp(v));
            rd_reg(8'h0_D);
            check(rd, v);
        end
        // Thermal event drops back to startup and holds there
        @(posedge clk_sys);
        thermal_shutdown <= 1'b1;
        wait_mode(PMSBC_STARTUP);
        repeat (3 * ST) @(posedge clk_sys);
        rd_reg(8'h0_E);
        check(rd, 8'h1_2);
        check({7'h0, led_enable}, 8'h0_0);
        @(posedge clk_sys);
        thermal_shutdown <= 1'b0;
        wait_mode(PMSBC_BOOST_SOFT);
        wait_mode(PMSBC_NORMAL);
        wr(8'h0_0, 8'h0_3);
        repeat (2) @(posedge clk_sys);
        #1 check(outs, 8'hC_2);
        wr(8'h0_0, 8'h0_5);
        repeat (2) @(posedge clk_sys);
        #1 check(outs, 8'hC_0);
        // Software parks the idle converter at the lowest code
        wr(8'h0_D, 8'h0_8);
        repeat (3) @(posedge clk_sys);
        #1 check(boost_target, 8'h0_8);
        wr(8'h0_0, 8'h0_0);
        wait_mode(PMSBC_STANDBY);
        check(outs, 8'h0_0);
        // Both reset sources, each from an active state
        for (k = 0; k < 2; k++) begin
            wr(8'h0_0, 8'h0_1);
            wr(8'h0_D, 8'h1_1);
            @(posedge clk_sys);
            if (k == 0) ext_reset_n <= 1'b0;
            else por_active <= 1'b1;
            repeat (3) @(posedge clk_sys);
            #1 check(8'(mode), 8'(PMSBC_RESET));
            @(posedge clk_sys);
            ext_reset_n <= 1'b1;
            por_active <= 1'b0;
            wait_mode(PMSBC_STANDBY);
            rd_reg(8'h0_0);
            check(rd, 8'h0_4);
            rd_reg(8'h0_D);
            check(rd, 8'h0_8);
        end
        final_report();
    end
endmodule
